/* src/lrl_pkg.sv */
package lrl_pkg;
	// register offsets (byte addresses, word aligned)
	localparam logic [3:0] LINE_TX_RX_CONTROL_REG = 4'h0;
	localparam logic [3:0] RX_IMPEDANCE_SENSITIVITY_MONITOR_REG = 4'h4;
	localparam logic [3:0] LINE_LATCHED_STATUS_REG = 4'h8;
	localparam logic [3:0] LINE_REAL_STATUS_REG = 4'hC;
	// control register fields
	localparam int CTL_E1_BIT = 0;
	localparam int CTL_ATTENUATOR_DEPTH_SELECT = 1;
	localparam int CTL_PATH_LO = 2;
	localparam int CTL_PATH_HI = 3;
	localparam int CTL_CRIT_LO = 4;
	localparam int CTL_CRIT_HI = 5;
	localparam int CTL_LOOP_LO = 6;
	localparam int CTL_LOOP_HI = 8;
	localparam int CTL_AUTO_ALARM_ON_LOSS = 9;
	localparam int CTL_TX_ALL_ONES = 10;
	localparam logic [10:0] CTL_RESET = 11'h000;
	// sensitivity / monitor register fields
	localparam int SENS_LO = 0;
	localparam int SENS_HI = 1;
	localparam int MON_LO = 2;
	localparam int MON_HI = 4;
	localparam int SYNC_CLK_EN_BIT = 5;
	localparam logic [5:0] SENS_RESET = 6'h00;
	// latched status bits
	localparam int ST_LOSS = 0;
	localparam int ST_ATTENUATOR_LIMIT_TRIP = 1;
	// path select codes
	localparam logic [1:0] PATH_OFF = 2'h0;
	localparam logic [1:0] PATH_TX = 2'h1;
	localparam logic [1:0] PATH_RX = 2'h2;
	// loss criteria codes
	localparam logic [1:0] CRIT_T1 = 2'h0;
	localparam logic [1:0] CRIT_ITU = 2'h1;
	localparam logic [1:0] CRIT_ETSI = 2'h2;
	// loopback codes
	localparam logic [2:0] LOOP_NONE = 3'h0;
	localparam logic [2:0] LOOP_ANALOG = 3'h1;
	localparam logic [2:0] LOOP_LOCAL = 3'h2;
	localparam logic [2:0] LOOP_REMOTE = 3'h3;
	localparam logic [2:0] LOOP_DUAL = 3'h4;
	// loss windows in bit periods
	localparam int LOSS_WIN_BITS = 192;
	localparam int ETSI_WIN_BITS = 2048;
	localparam int MIN_ONES = 24;
	localparam int MAX_ZERO_RUN = 100;
	// attenuator depths and trip limits
	localparam int DEPTH_SHORT = 32;
	localparam int DEPTH_LONG = 128;
	localparam int TRIP_SHORT_UI = 28;
	localparam int TRIP_LONG_UI = 120;
	// smoothing step shift per mode (corner 3.75Hz vs 0.6Hz)
	localparam int SMOOTH_SHIFT_T1 = 6;
	localparam int SMOOTH_SHIFT_E1 = 9;
	// level codes: sensitivity in dB of cable loss
	localparam logic [5:0] SENS_DB_12 = 6'h0C;
	localparam logic [5:0] SENS_DB_18 = 6'h12;
	localparam logic [5:0] SENS_DB_30 = 6'h1E;
	localparam logic [5:0] SENS_DB_38 = 6'h26;
	localparam logic [5:0] SENS_DB_45 = 6'h2D;
	localparam logic [5:0] HYST_DB = 6'h03;
	localparam logic [5:0] MON_STEP_DB = 6'h08;

	typedef struct packed {
		logic pos;
		logic neg;
	} lrl_pair_t;
endpackage

/* src/lrl_sync2.sv */
`timescale 1ns/1ps
module lrl_sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

/* src/lrl_line_rx.sv */
`timescale 1ns/1ps
module lrl_line_rx (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bit_tick_i,
	input wire logic transmit_clock_in_i,
	input wire logic framer_tx_serial_i,
	input wire lrl_pkg::lrl_pair_t tx_pulse_i,
	input wire lrl_pkg::lrl_pair_t line_rx_i,
	input wire logic [5:0] line_rx_level_db_i,
	output lrl_pkg::lrl_pair_t line_tx_o,
	output logic framer_rx_serial_o,
	output logic rx_clock_o,
	output logic attenuator_ref_clock_o,
	output logic loss_o
);
	logic [10:0] ctl;
	logic [5:0] sens;
	logic [1:0] lstat;
	logic [31:0] next_rdata;
	logic rd_pend;
	logic tck_s, framer_tx_serial_s, transmit_clock_in_s, transmit_clock_in_d;
	logic [5:0] lvl_s;
	lrl_pkg::lrl_pair_t rx_s, txp_s;
	logic [1:0] path;
	logic [2:0] loop;
	logic [1:0] crit;
	logic deep, is_e1;
	logic [5:0] sens_db, gain_db, eff_lvl, decl_db;
	logic pulse_seen, above_sens, below_decl;
	lrl_pkg::lrl_pair_t rx_sel, fifo_in, fifo_out;
	logic loss, next_loss;
	logic [11:0] low_cnt, win_cnt, good_cnt;
	logic [7:0] ones_cnt;
	logic [6:0] zrun;
	logic zrun_hit;
	logic [127:0] fpos, fneg;
	logic [6:0] wptr, rptr;
	logic [7:0] fill;
	logic [7:0] depth;
	logic [15:0] phase;
	logic smooth_tick, in_tick, rx_clk_rec;
	logic fifo_en;

	// input synchronisers: two flops before any logic; bit_tick_i is used directly without them
	lrl_sync2 #(.W(12)) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({transmit_clock_in_i, framer_tx_serial_i, tx_pulse_i, line_rx_i, line_rx_level_db_i}),
		.q_o({transmit_clock_in_s, framer_tx_serial_s, txp_s, rx_s, lvl_s})
	);
	assign tck_s = bit_tick_i;

	assign is_e1 = ctl[lrl_pkg::CTL_E1_BIT];
	assign deep = ctl[lrl_pkg::CTL_ATTENUATOR_DEPTH_SELECT];
	assign path = ctl[lrl_pkg::CTL_PATH_HI:lrl_pkg::CTL_PATH_LO];
	assign crit = ctl[lrl_pkg::CTL_CRIT_HI:lrl_pkg::CTL_CRIT_LO];
	assign loop = ctl[lrl_pkg::CTL_LOOP_HI:lrl_pkg::CTL_LOOP_LO];

	// avalon slave, one wait state on read
	assign avs_waitrequest = avs_read & ~rd_pend;
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (avs_address)
			lrl_pkg::LINE_TX_RX_CONTROL_REG: next_rdata = {21'h000000, ctl};
			lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG: next_rdata = {26'h0000000, sens};
			lrl_pkg::LINE_LATCHED_STATUS_REG: next_rdata = {30'h00000000, lstat};
			lrl_pkg::LINE_REAL_STATUS_REG: next_rdata = {24'h000000, fill[7:1], loss};
			default: next_rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_pend <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			rd_pend <= avs_read & ~rd_pend;
			if (avs_read & ~rd_pend) begin
				avs_readdata <= next_rdata;
			end
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl <= lrl_pkg::CTL_RESET;
			sens <= lrl_pkg::SENS_RESET;
		end else if (avs_write) begin
			if (avs_address == lrl_pkg::LINE_TX_RX_CONTROL_REG) begin
				if (avs_byteenable[0]) begin
					ctl[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					ctl[10:8] <= avs_writedata[10:8];
				end
			end
			if (avs_address == lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG && avs_byteenable[0]) begin
				sens <= avs_writedata[5:0];
			end
		end
	end

	// sensitivity: code 0..3 maps onto short and long haul ranges
	always_comb begin
		case (sens[lrl_pkg::SENS_HI:lrl_pkg::SENS_LO])
			2'h0: sens_db = lrl_pkg::SENS_DB_12;
			2'h1: sens_db = lrl_pkg::SENS_DB_18;
			2'h2: sens_db = lrl_pkg::SENS_DB_30;
			2'h3: sens_db = is_e1 ? lrl_pkg::SENS_DB_45 : lrl_pkg::SENS_DB_38;
			default: sens_db = lrl_pkg::SENS_DB_12;
		endcase
	end
	// monitor gain in 8dB steps, 4 steps = 32dB
	assign gain_db = 6'(sens[lrl_pkg::MON_HI:lrl_pkg::MON_LO] > 3'h4 ? 3'h4 : sens[lrl_pkg::MON_HI:lrl_pkg::MON_LO])
		* lrl_pkg::MON_STEP_DB;
	// level is loss in dB; monitor gain reduces it
	assign eff_lvl = (lvl_s > gain_db) ? 6'(lvl_s - gain_db) : 6'h00;
	assign decl_db = 6'(sens_db + lrl_pkg::HYST_DB);
	assign below_decl = eff_lvl >= decl_db;
	assign above_sens = eff_lvl <= sens_db;

	// receiver input select
	always_comb begin
		case (loop)
			lrl_pkg::LOOP_ANALOG: rx_sel = line_tx_o;
			lrl_pkg::LOOP_LOCAL, lrl_pkg::LOOP_DUAL: rx_sel = txp_s;
			default: rx_sel = rx_s;
		endcase
	end
	// sync clock mode: square wave counts as marks every bit
	assign pulse_seen = sens[lrl_pkg::SYNC_CLK_EN_BIT] ? 1'b1 : (rx_sel.pos | rx_sel.neg);

	// loss detection counters per bit period
	assign zrun_hit = zrun >= 7'(lrl_pkg::MAX_ZERO_RUN);
	always_comb begin
		next_loss = loss;
		if (!loss) begin
			if (crit == lrl_pkg::CRIT_ETSI) begin
				next_loss = low_cnt >= 12'(lrl_pkg::ETSI_WIN_BITS);
			end else begin
				next_loss = low_cnt >= 12'(lrl_pkg::LOSS_WIN_BITS);
			end
		end else if (crit == lrl_pkg::CRIT_T1) begin
			next_loss = !(win_cnt == 12'(lrl_pkg::LOSS_WIN_BITS) && ones_cnt >= 8'(lrl_pkg::MIN_ONES)
				&& !zrun_hit);
		end else begin
			next_loss = good_cnt < 12'(lrl_pkg::LOSS_WIN_BITS);
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			loss <= 1'b0;
			low_cnt <= 12'h000;
			good_cnt <= 12'h000;
			win_cnt <= 12'h000;
			ones_cnt <= 8'h00;
			zrun <= 7'h00;
		end else if (tck_s) begin
			loss <= next_loss;
			low_cnt <= (below_decl || !pulse_seen) ? (low_cnt == 12'hFFF ? low_cnt : 12'(low_cnt + 12'h001)) : 12'h000;
			good_cnt <= (above_sens && pulse_seen) ? (good_cnt == 12'hFFF ? good_cnt : 12'(good_cnt + 12'h001))
				: 12'h000;
			if (next_loss != loss || win_cnt == 12'(lrl_pkg::LOSS_WIN_BITS)) begin
				win_cnt <= 12'h001;
				ones_cnt <= {7'h00, pulse_seen & above_sens};
				zrun <= pulse_seen ? 7'h00 : 7'h01;
			end else begin
				win_cnt <= 12'(win_cnt + 12'h001);
				ones_cnt <= 8'(ones_cnt + {7'h00, pulse_seen & above_sens});
				zrun <= pulse_seen ? 7'h00 : (zrun_hit ? zrun : 7'(zrun + 7'h01));
			end
		end
	end
	assign loss_o = loss;

	// attenuator input: receive pair or transmit pulses
	assign fifo_en = path != lrl_pkg::PATH_OFF;
	assign fifo_in = (path == lrl_pkg::PATH_TX) ? txp_s : rx_sel;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			transmit_clock_in_d <= 1'b0;
		end else begin
			transmit_clock_in_d <= transmit_clock_in_s;
		end
	end
	// gapped transmit clock simply writes fewer bits
	assign in_tick = (path == lrl_pkg::PATH_TX) ? (transmit_clock_in_s & ~transmit_clock_in_d) : tck_s;
	assign rx_clk_rec = tck_s;
	assign depth = deep ? 8'(lrl_pkg::DEPTH_LONG) : 8'(lrl_pkg::DEPTH_SHORT);

	// smoothing phase accumulator nudged by fill error
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase <= 16'h0000;
		end else if (in_tick) begin
			phase <= 16'(phase + 16'h0001);
		end else if (fill > (depth >> 1) && phase[15 - (is_e1 ? lrl_pkg::SMOOTH_SHIFT_E1 : lrl_pkg::SMOOTH_SHIFT_T1)]) begin
			phase <= 16'h0000;
		end
	end
	// smoothed read strobe: follows input rate, centred on half depth
	assign smooth_tick = fifo_en && fill != 8'h00 && (fill >= (depth >> 1) ? in_tick | (fill == depth) : in_tick
		& phase[0]);

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wptr <= 7'h00;
			rptr <= 7'h00;
			fill <= 8'h00;
			fifo_out <= '0;
		end else if (!fifo_en) begin
			wptr <= 7'h00;
			rptr <= 7'h00;
			fill <= 8'h00;
			fifo_out <= fifo_in;
		end else begin
			if (in_tick && fill < depth) begin
				fpos[wptr] <= fifo_in.pos;
				fneg[wptr] <= fifo_in.neg;
				wptr <= (wptr == 7'(depth - 8'h01)) ? 7'h00 : 7'(wptr + 7'h01);
			end
			if (smooth_tick) begin
				fifo_out <= '{pos: fpos[rptr], neg: fneg[rptr]};
				rptr <= (rptr == 7'(depth - 8'h01)) ? 7'h00 : 7'(rptr + 7'h01);
			end
			fill <= 8'(fill + {7'h00, in_tick && fill < depth} - {7'h00, smooth_tick});
		end
	end
	// fpos/fneg hold no reset: a slot is read only once written

	// latched status, write one to clear, set wins
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lstat <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (avs_write && avs_address == lrl_pkg::LINE_LATCHED_STATUS_REG && avs_byteenable[0]
					&& avs_writedata[i]) begin
					lstat[i] <= 1'b0;
				end
			end
			if (next_loss & ~loss & tck_s) begin
				lstat[lrl_pkg::ST_LOSS] <= 1'b1;
			end
			// overflow when fill reaches the trip limit for the selected depth on a write
			if (fifo_en && in_tick && fill >= (deep ? 8'(lrl_pkg::TRIP_LONG_UI) : 8'(lrl_pkg::TRIP_SHORT_UI))) begin
				lstat[lrl_pkg::ST_ATTENUATOR_LIMIT_TRIP] <= 1'b1;
			end
		end
	end

	// line transmit and framer receive data
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line_tx_o <= '0;
			framer_rx_serial_o <= 1'b0;
			attenuator_ref_clock_o <= 1'b0;
			rx_clock_o <= 1'b0;
		end else begin
			framer_rx_serial_o <= (path == lrl_pkg::PATH_RX) ? (fifo_out.pos | fifo_out.neg)
				: (rx_sel.pos | rx_sel.neg);
			if (ctl[lrl_pkg::CTL_TX_ALL_ONES] || (loss && ctl[lrl_pkg::CTL_AUTO_ALARM_ON_LOSS])) begin
				line_tx_o <= '{pos: ~line_tx_o.pos, neg: line_tx_o.pos};
			end else if (loop == lrl_pkg::LOOP_REMOTE || loop == lrl_pkg::LOOP_DUAL) begin
				line_tx_o <= rx_s;
			end else if (path == lrl_pkg::PATH_TX) begin
				line_tx_o <= fifo_out;
			end else begin
				line_tx_o <= '{pos: framer_tx_serial_s & txp_s.pos, neg: txp_s.neg};
			end
			attenuator_ref_clock_o <= fifo_en ? smooth_tick : tck_s;
			rx_clock_o <= loss ? attenuator_ref_clock_o : rx_clk_rec;
		end
	end

	lrl_loss_enter_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(tck_s && !loss && crit == lrl_pkg::CRIT_T1 && low_cnt >= 12'(lrl_pkg::LOSS_WIN_BITS)) |=> loss)
		else $error("loss not declared after 192 bits");
	lrl_etsi_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(tck_s && !loss && crit == lrl_pkg::CRIT_ETSI && low_cnt < 12'(lrl_pkg::ETSI_WIN_BITS)) |=> !loss)
		else $error("etsi loss declared early");
	lrl_alarm_ones_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(loss && ctl[lrl_pkg::CTL_AUTO_ALARM_ON_LOSS] && $past(loss) && $past(ctl[lrl_pkg::CTL_AUTO_ALARM_ON_LOSS]))
		|=> (line_tx_o.pos != $past(line_tx_o.pos)))
		else $error("alarm ones not sent");
	lrl_rxclk_src_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		loss |=> rx_clock_o == $past(attenuator_ref_clock_o))
		else $error("rx clock not from reference");
	lrl_fill_limit_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		fill <= depth)
		else $error("fifo over depth");
	lrl_remote_loop_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(loop == lrl_pkg::LOOP_REMOTE && !ctl[lrl_pkg::CTL_TX_ALL_ONES] && !(loss && ctl[lrl_pkg::CTL_AUTO_ALARM_ON_LOSS]))
		|=> line_tx_o == $past(rx_s))
		else $error("remote loop not returned");
	lrl_trip_set_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(fifo_en && in_tick && deep && fill >= 8'(lrl_pkg::TRIP_LONG_UI)) |=> lstat[lrl_pkg::ST_ATTENUATOR_LIMIT_TRIP])
		else $error("limit trip not latched");
	lrl_t1_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(tck_s && loss && crit == lrl_pkg::CRIT_T1 && zrun_hit) |=> loss)
		else $error("loss cleared despite zero run");
	lrl_loss_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(tck_s && next_loss && !loss) |=> lstat[lrl_pkg::ST_LOSS])
		else $error("loss entry not latched");
	lrl_itu_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(tck_s && loss && crit == lrl_pkg::CRIT_ITU && good_cnt < 12'(lrl_pkg::LOSS_WIN_BITS)) |=> loss)
		else $error("itu loss cleared early");
	lrl_path_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(path == lrl_pkg::PATH_OFF) |=> fill == 8'h00)
		else $error("fifo not emptied when off");
endmodule

/* test/lrl_line_partner.sv */
`timescale 1ns/1ps
module lrl_line_partner (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] pulse_every_i,
	input wire logic [5:0] level_db_i,
	output logic bit_tick_o,
	output lrl_pkg::lrl_pair_t line_rx_o,
	output logic [5:0] line_rx_level_db_o
);
	logic [1:0] phase;
	logic [7:0] bit_cnt;
	logic mark_neg;
	// one line bit every four system clocks
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase <= 2'h0;
			bit_tick_o <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			bit_tick_o <= (phase == 2'h3);
		end
	end
	// alternate mark polarity, one mark every pulse_every_i bits
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bit_cnt <= 8'h00;
			mark_neg <= 1'b0;
			line_rx_o <= '0;
		end else if (phase == 2'h3) begin
			if (pulse_every_i != 8'h00 && bit_cnt == 8'h00) begin
				line_rx_o <= mark_neg ? 2'b01 : 2'b10;
				mark_neg <= ~mark_neg;
			end else begin
				line_rx_o <= '0;
			end
			bit_cnt <= (bit_cnt + 8'h01 >= pulse_every_i) ? 8'h00 : bit_cnt + 8'h01;
		end
	end
	assign line_rx_level_db_o = level_db_i;
endmodule

/* test/lrl_line_rx_tb.sv */
`timescale 1ns/1ps
module lrl_line_rx_tb;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic bit_tick;
	logic tx_clock = 1'b0;
	logic tx_serial = 1'b0;
	lrl_pkg::lrl_pair_t tx_pulse = '0;
	lrl_pkg::lrl_pair_t line_rx;
	lrl_pkg::lrl_pair_t line_tx;
	logic [5:0] level_db;
	logic [5:0] level_set = 6'h06;
	logic [7:0] pulse_every = 8'h01;
	logic loss;
	logic [3:0] gap = 4'h0;
	logic [31:0] rd;
	logic framer_rx;
	logic rx_clock;
	logic ref_clock;
	logic ref_prev;
	lrl_pkg::lrl_pair_t pair;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	always #10 sys_clk_i = ~sys_clk_i;

	lrl_line_partner far_end (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pulse_every_i(pulse_every),
		.level_db_i(level_set), .bit_tick_o(bit_tick), .line_rx_o(line_rx), .line_rx_level_db_o(level_db));

	lrl_line_rx dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.bit_tick_i(bit_tick), .transmit_clock_in_i(tx_clock), .framer_tx_serial_i(tx_serial),
		.tx_pulse_i(tx_pulse), .line_rx_i(line_rx), .line_rx_level_db_i(level_db), .line_tx_o(line_tx),
		.framer_rx_serial_o(framer_rx), .rx_clock_o(rx_clock), .attenuator_ref_clock_o(ref_clock), .loss_o(loss));

	// framer side traffic with a gapped transmit clock
	always @(posedge sys_clk_i) begin
		gap <= gap + 4'h1;
		tx_clock <= (gap[3:2] != 2'h3) ? ~tx_clock : tx_clock;
		tx_serial <= gap[1];
		tx_pulse <= {gap[0] & gap[2], ~gap[0] & gap[2]};
	end

	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			$display("unexpected at %0t: run too long", $time);
			results();
		end
	end

	task automatic results;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus_wait;
		@(posedge sys_clk_i);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge sys_clk_i);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		avs_write <= 1'b1;
		bus_wait();
		avs_write <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a);
		@(posedge sys_clk_i);
		avs_address <= a;
		avs_read <= 1'b1;
		bus_wait();
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task automatic set_line(input logic [7:0] p, input logic [5:0] l);
		@(posedge sys_clk_i);
		pulse_every <= p;
		level_set <= l;
	endtask

	task automatic wait_bits(input int n);
		repeat (n) @(posedge sys_clk_i iff bit_tick === 1'b1);
		@(negedge sys_clk_i);
	endtask

	task automatic chk_loss(input logic e, input string what);
		check({31'h0, loss}, {31'h0, e}, what);
	endtask

	task automatic declare_clear(input int low, input int high, input int keep, input string name);
		set_line(8'h00, 6'h14);
		wait_bits(low);
		chk_loss(1'b0, {name, " early"});
		wait_bits(high - low);
		chk_loss(1'b1, {name, " declare"});
		set_line(8'h01, 6'h06);
		wait_bits(keep);
		chk_loss(1'b1, {name, " clear early"});
		wait_bits(210 - keep);
		chk_loss(1'b0, {name, " clear"});
		$display("test %s done", name);
	endtask

	initial begin
		repeat (10) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		reg_read(lrl_pkg::LINE_TX_RX_CONTROL_REG);
		check(rd, 32'h0, "control reset");
		reg_read(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG);
		check(rd, 32'h0, "sensitivity reset");
		for (int i = 0; i < 5; i++) begin
			reg_write(lrl_pkg::LINE_TX_RX_CONTROL_REG, (32'(i) << 6) | (32'(i % 3) << 2) | (32'(i & 1) << 1));
			reg_read(lrl_pkg::LINE_TX_RX_CONTROL_REG);
			check(rd, (32'(i) << 6) | (32'(i % 3) << 2) | (32'(i & 1) << 1), "loop path depth");
		end
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h33);
		reg_read(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG);
		check(rd, 32'h33, "sync clock and monitor gain");
		reg_write(4'h2, 32'h7FF);
		reg_read(4'h2);
		check(rd, 32'h0, "unmapped read");
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h0);
		reg_write(lrl_pkg::LINE_TX_RX_CONTROL_REG, 32'hA);
		chk_loss(1'b0, "no loss with good line");
		$display("test registers done");
		set_line(8'h00, 6'h14);
		wait_bits(180);
		chk_loss(1'b0, "t1 early");
		wait_bits(20);
		chk_loss(1'b1, "t1 declare");
		check({31'h0, framer_rx}, 32'h0, "attenuator drains zeros");
		reg_read(lrl_pkg::LINE_REAL_STATUS_REG);
		check(rd & 32'h1, 32'h1, "real loss");
		reg_read(lrl_pkg::LINE_LATCHED_STATUS_REG);
		check(rd & 32'h1, 32'h1, "latched loss");
		reg_write(lrl_pkg::LINE_LATCHED_STATUS_REG, 32'h1);
		reg_read(lrl_pkg::LINE_LATCHED_STATUS_REG);
		check(rd & 32'h1, 32'h0, "latched loss cleared");
		reg_write(lrl_pkg::LINE_TX_RX_CONTROL_REG, 32'h20A);
		repeat (3) @(negedge sys_clk_i);
		pair = line_tx;
		@(negedge sys_clk_i);
		check({30'h0, line_tx}, {30'h0, pair.neg, pair.pos}, "alarm ones alternate");
		check({31'h0, pair.pos ^ pair.neg}, 32'h1, "alarm ones marked");
		reg_write(lrl_pkg::LINE_TX_RX_CONTROL_REG, 32'hA);
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk_i);
			ref_prev = ref_clock;
			@(negedge sys_clk_i);
			check({31'h0, rx_clock}, {31'h0, ref_prev}, "rx clock from reference");
		end
		set_line(8'h01, 6'h0D);
		wait_bits(400);
		chk_loss(1'b1, "hysteresis keeps loss");
		set_line(8'h0A, 6'h06);
		wait_bits(500);
		chk_loss(1'b1, "sparse ones keep loss");
		set_line(8'h01, 6'h06);
		wait_bits(400);
		chk_loss(1'b0, "t1 clear");
		check({31'h0, framer_rx}, 32'h1, "attenuator passes marks");
		set_line(8'h01, 6'h0D);
		wait_bits(300);
		chk_loss(1'b0, "between levels no loss");
		$display("test t1 done");
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h2);
		set_line(8'h01, 6'h1E);
		wait_bits(300);
		chk_loss(1'b0, "long haul at sensitivity");
		set_line(8'h01, 6'h22);
		wait_bits(210);
		chk_loss(1'b1, "long haul below threshold");
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h0);
		set_line(8'h01, 6'h06);
		wait_bits(400);
		chk_loss(1'b0, "short haul recovers");
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h20);
		set_line(8'h00, 6'h06);
		wait_bits(250);
		chk_loss(1'b0, "sync clock counts as signal");
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h08);
		set_line(8'h01, 6'h14);
		wait_bits(250);
		chk_loss(1'b0, "monitor gain lifts level");
		set_line(8'h01, 6'h06);
		reg_write(lrl_pkg::RX_IMPEDANCE_SENSITIVITY_MONITOR_REG, 32'h0);
		wait_bits(4);
		$display("test sensitivity done");
		reg_write(lrl_pkg::LINE_TX_RX_CONTROL_REG, 32'h1B);
		declare_clear(180, 200, 150, "itu");
		reg_write(lrl_pkg::LINE_TX_RX_CONTROL_REG, 32'h2B);
		declare_clear(1900, 2100, 150, "etsi");
		results();
	end
endmodule
